// *** hw/rsap_host.v ***
`timescale 1ns/1ps
`include "rsap_defines.vh"
module rsap_host (
   clk,
   resetn,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   power_fail,
   addr_in,
   data_o,
   data_oe,
   data_i,
   chip_sel_n,
   out_en_n,
   wr_strobe_n
);
   input         clk;
   input         resetn;
   input  [3:0]  avs_address;
   input         avs_read;
   input         avs_write;
   input  [31:0] avs_writedata;
   output [31:0] avs_readdata;
   output        avs_waitrequest;
   input         power_fail;
   output [10:0] addr_in;
   output [7:0]  data_o;
   output        data_oe;
   input  [7:0]  data_i;
   output        chip_sel_n;
   output        out_en_n;
   output        wr_strobe_n;

   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_RD_AC = 3'd1;
   localparam [2:0] ST_WR_LO = 3'd2;
   localparam [2:0] ST_WR_HD = 3'd3;
   localparam [2:0] ST_RECOV = 3'd4;

   localparam integer CYC_RD_N   = `RSAP_CYC_UP(`RSAP_T_ADDR_ACC_NS) + 1;
   localparam integer CYC_WR_N   = `RSAP_CYC_UP(`RSAP_T_STROBE_W_NS + 10);
   localparam integer CYC_HOLD_N = `RSAP_CYC_UP(`RSAP_T_HOLD_NS);
   localparam integer CYC_REC_N  = `RSAP_CYC_UP(`RSAP_T_RECOV_NS);
   localparam integer CYC_FLT_N  = `RSAP_CYC_UP(`RSAP_T_FLOAT_NS);
   localparam [3:0]   CYC_RD     = CYC_RD_N[3:0];
   localparam [3:0]   CYC_WR     = CYC_WR_N[3:0];
   localparam [3:0]   CYC_HOLD   = CYC_HOLD_N[3:0];
   localparam [3:0]   CYC_REC    = CYC_REC_N[3:0];
   localparam [3:0]   CYC_FLT    = CYC_FLT_N[3:0];

   reg [2:0]  st_ff;
   reg [2:0]  nxt_st;
   reg [10:0] addr_ff;
   reg [7:0]  wdata_ff;
   reg [7:0]  rdata_ff;
   reg        wr_dir_ff;
   reg        selw_ff;
   reg        done_ff;
   reg        busy_ff;
   reg        ce_n_ff;
   reg        oe_n_ff;
   reg        we_n_ff;
   reg        doe_ff;
   reg [31:0] rd_ff;
   reg        wait_ff;
   reg        pf_s1_ff;
   reg        pf_s2_ff;
   reg [7:0]  di_s1_ff;
   reg [7:0]  di_s2_ff;
   reg        tmr_load;
   reg [3:0]  tmr_count;
   wire       tmr_done;
   wire       go_wr;
   wire       go_start;

   assign avs_readdata    = rd_ff;
   assign avs_waitrequest = wait_ff;
   assign addr_in         = addr_ff;
   assign data_o          = wdata_ff;
   assign data_oe         = doe_ff;
   assign chip_sel_n      = ce_n_ff;
   assign out_en_n        = oe_n_ff;
   assign wr_strobe_n     = we_n_ff;

   assign go_wr    = avs_write && !wait_ff &&
                     (avs_address == `RSAP_REG_CTRL);
   assign go_start = go_wr && avs_writedata[`RSAP_CTRL_GO_BIT] &&
                     (st_ff == ST_IDLE) && !pf_s2_ff;

   rsap_timer u_timer (
      .clk     (clk),
      .resetn  (resetn),
      .load    (tmr_load),
      .count   (tmr_count),
      .expired (tmr_done)
   );

   always @* begin
      nxt_st    = st_ff;
      tmr_load  = 1'b0;
      tmr_count = 4'h0;
      case (st_ff)
         ST_IDLE: begin
            if (go_start) begin
               tmr_load = 1'b1;
               if (avs_writedata[`RSAP_CTRL_WRITE_BIT]) begin
                  nxt_st    = ST_WR_LO;
                  tmr_count = CYC_WR;
               end else begin
                  nxt_st    = ST_RD_AC;
                  tmr_count = CYC_RD;
               end
            end
         end
         ST_RD_AC: begin
            if (tmr_done) begin
               nxt_st    = ST_RECOV;
               tmr_load  = 1'b1;
               tmr_count = CYC_FLT;
            end
         end
         ST_WR_LO: begin
            if (tmr_done) begin
               nxt_st    = ST_WR_HD;
               tmr_load  = 1'b1;
               tmr_count = CYC_HOLD;
            end
         end
         ST_WR_HD: begin
            if (tmr_done) begin
               nxt_st    = ST_RECOV;
               tmr_load  = 1'b1;
               tmr_count = CYC_REC;
            end
         end
         ST_RECOV: begin
            if (tmr_done) begin
               nxt_st = ST_IDLE;
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         pf_s1_ff <= 1'b0;
         pf_s2_ff <= 1'b0;
         di_s1_ff <= 8'h00;
         di_s2_ff <= 8'h00;
      end else begin
         pf_s1_ff <= power_fail;
         pf_s2_ff <= pf_s1_ff;
         di_s1_ff <= data_i;
         di_s2_ff <= di_s1_ff;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         st_ff     <= ST_IDLE;
         addr_ff   <= 11'h000;
         wdata_ff  <= 8'h00;
         rdata_ff  <= 8'h00;
         wr_dir_ff <= 1'b0;
         selw_ff   <= 1'b0;
         done_ff   <= 1'b0;
         busy_ff   <= 1'b0;
         ce_n_ff   <= 1'b1;
         oe_n_ff   <= 1'b1;
         we_n_ff   <= 1'b1;
         doe_ff    <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         busy_ff <= (nxt_st != ST_IDLE);
         if (avs_write && !wait_ff && st_ff == ST_IDLE) begin
            if (avs_address == `RSAP_REG_ADDR) begin
               addr_ff <= avs_writedata[10:0]; // [R08] [R01] [R04]
            end
            if (avs_address == `RSAP_REG_WDATA) begin
               wdata_ff <= avs_writedata[7:0];
            end
         end
         if (go_start) begin
            wr_dir_ff <= avs_writedata[`RSAP_CTRL_WRITE_BIT];
            selw_ff   <= avs_writedata[`RSAP_CTRL_SELW_BIT];
            ce_n_ff   <= 1'b0;
            if (avs_writedata[`RSAP_CTRL_WRITE_BIT]) begin
               // Output enable stays high so the bus never fights. [R17]
               oe_n_ff <= 1'b1;
               doe_ff  <= 1'b1; // [R16]
               // Both strobes fall together; the mode picks which one
               // rises first and so ends the write. [R13]
               we_n_ff <= 1'b0;
            end else begin
               oe_n_ff <= 1'b0; // [R07] [R09]
               we_n_ff <= 1'b1;
            end
         end else if (go_wr && avs_writedata[`RSAP_CTRL_GO_BIT]) begin
            done_ff <= done_ff;
         end else if (go_wr) begin
            done_ff <= 1'b0;
         end
         if (st_ff == ST_RD_AC && tmr_done) begin
            // Two synchroniser stages were allowed for in the wait. [R12]
            rdata_ff <= di_s2_ff; // [R10] [R11]
            ce_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            done_ff  <= 1'b1;
         end
         if (st_ff == ST_WR_LO && tmr_done) begin
            // The address stays put until the other strobe rises. [R14]
            if (selw_ff) begin
               ce_n_ff <= 1'b1; // [R20]
            end else begin
               we_n_ff <= 1'b1; // [R19]
            end
         end
         if (st_ff == ST_WR_HD && tmr_done) begin
            ce_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            doe_ff  <= 1'b0; // [R16]
            done_ff <= 1'b1; // [R15]
         end
         if (pf_s2_ff && st_ff == ST_WR_LO) begin
            done_ff <= 1'b0; // [R06] [R24]
         end
      end
   end

   // Reads are answered one cycle after they are first seen.
   always @(posedge clk) begin
      if (!resetn) begin
         wait_ff <= 1'b1;
         rd_ff   <= 32'h00000000;
      end else begin
         wait_ff <= !(wait_ff && (avs_read || avs_write));
         if (wait_ff && avs_read) begin
            case (avs_address)
               `RSAP_REG_CTRL:   rd_ff <= {29'h0, selw_ff, wr_dir_ff, 1'b0};
               `RSAP_REG_ADDR:   rd_ff <= {21'h0, addr_ff};
               `RSAP_REG_WDATA:  rd_ff <= {24'h0, wdata_ff};
               `RSAP_REG_STATUS: rd_ff <= {16'h0, rdata_ff, 5'h0,
                                           pf_s2_ff, done_ff, busy_ff};
               default:          rd_ff <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// *** hw/rsap_defines.vh ***
// Notes on behaviour
// [R01] Top eight bytes 7f8-7ff are clock bytes.
// [R02] Clock bytes hold BCD time, 24-hour.
// [R03] Device calendar handles month lengths, leap years.
// [R04] Byte 7f8 is the clock control byte.
// [R05] Device copies time into clock bytes each second.
// [R06] Device blocks writes during supply fault.
// [R07] Select low, strobe high means read mode.
// [R08] Eleven address lines pick one of 2048 bytes.
// [R09] Device drives data only when selected and enabled.
// [R10] Data undefined until all access delays pass.
// [R11] Address change keeps data briefly, then undefined; the model drops valid data at once.
// [R12] Read data valid within address access limit.
// [R13] Write spans strobe overlap, commits at end.
// [R14] Host holds address stable through write cycle.
// [R15] Host keeps strobe high for recovery after write.
// [R16] Host sets data 30 ns before, holds 5 ns.
// [R17] Host keeps output enable high during writes.
// [R18] Device floats data within 25 ns of strobe.
// [R19] Host holds write strobe low at least 50 ns.
// [R20] Select-controlled write keeps select low 55 ns.
// [R21] Read-halt bit freezes clock byte updates.
// [R22] Write-halt bit freezes; clearing loads counters.
// [R23] Host access beats the once-per-second refresh.
// [R24] Power fail floats data, ignores host strobes.
`ifndef RSAP_DEFINES_VH
`define RSAP_DEFINES_VH
`define RSAP_CLK_MHZ          40
`define RSAP_T_ADDR_ACC_NS    70
`define RSAP_T_OE_ACC_NS      35
`define RSAP_T_STROBE_W_NS    50
`define RSAP_T_SETUP_NS       30
`define RSAP_T_HOLD_NS        5
`define RSAP_T_RECOV_NS       10
`define RSAP_T_FLOAT_NS       25
`define RSAP_CYC_UP(ns)       (((ns) * `RSAP_CLK_MHZ + 999) / 1000)
`define RSAP_REG_CTRL         4'h0
`define RSAP_REG_ADDR         4'h4
`define RSAP_REG_WDATA        4'h8
`define RSAP_REG_STATUS       4'hc
`define RSAP_CTRL_GO_BIT      0
`define RSAP_CTRL_WRITE_BIT   1
`define RSAP_CTRL_SELW_BIT    2
`define RSAP_STAT_BUSY_BIT    0
`define RSAP_STAT_DONE_BIT    1
`define RSAP_STAT_PFAIL_BIT   2
`define RSAP_STAT_RDATA_LSB   8
`define RSAP_CLK_BASE         11'h7f8
`define RSAP_CTRL_READ_HALT   6
`define RSAP_CTRL_WRITE_HALT  7
`endif

// *** hw/rsap_timer.v ***
`timescale 1ns/1ps
`include "rsap_defines.vh"
module rsap_timer (
   clk,
   resetn,
   load,
   count,
   expired
);
   input        clk;
   input        resetn;
   input        load;
   input  [3:0] count;
   output       expired;
   reg    [3:0] cnt_ff;
   reg          expired_ff;
   assign expired = expired_ff;
   always @(posedge clk) begin
      if (!resetn) begin
         cnt_ff     <= 4'h0;
         expired_ff <= 1'b1;
      end else if (load) begin
         cnt_ff     <= count;
         expired_ff <= (count == 4'h0);
      end else if (cnt_ff != 4'h0) begin
         cnt_ff     <= cnt_ff - 4'h1;
         expired_ff <= (cnt_ff == 4'h1);
      end
   end
endmodule

// *** verification/rsap_host_sva.sv ***
`timescale 1ns/1ps
module rsap_host_sva (
   input wire        clk,
   input wire        resetn,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire [10:0] addr_in,
   input wire [7:0]  data_o,
   input wire        data_oe,
   input wire        chip_sel_n,
   input wire        out_en_n,
   input wire        wr_strobe_n
);
   wire wr_act = !chip_sel_n && !wr_strobe_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   req_ans_a: assert property
      ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer");
   oe_write_a: assert property (wr_act |-> out_en_n)
      else $error("oe low in write");
   addr_hold_a: assert property (wr_act |=> $stable(addr_in))
      else $error("addr moved");
   strobe_width_a: assert property
      ($fell(wr_strobe_n) |-> !wr_strobe_n ##1 !wr_strobe_n)
      else $error("strobe short");
   sel_width_a: assert property
      ($fell(chip_sel_n) |-> !chip_sel_n [*3])
      else $error("select short");
   data_setup_a: assert property ($fell(wr_act) |-> data_oe
      && $past(data_oe, 2) && $stable(data_o) && $past(data_o, 2) == data_o)
      else $error("data setup");
   data_hold_a: assert property ($fell(wr_act) |=> data_oe
      && $stable(data_o))
      else $error("data hold");
   recover_a: assert property ($fell(wr_act) |=> !wr_act [*2])
      else $error("no recovery");
   cover property ($fell(wr_act));
   cover property (!chip_sel_n && !out_en_n);
   cover property (avs_read && !avs_waitrequest);
endmodule

// *** verification/rsap_dev_model.sv ***
`timescale 1ns/1ps
module rsap_dev_model (
   input  wire        clk,
   input  wire [10:0] addr_in,
   input  wire        chip_sel_n,
   input  wire        out_en_n,
   input  wire        wr_strobe_n,
   input  wire        power_fail,
   input  wire [7:0]  host_d,
   input  wire        host_oe,
   output wire [7:0]  dev_d
);
   // Clock and control bytes sit in the same array; the refresh below rewrites the clock bytes.
   logic [7:0] mem [0:2047];
   logic [7:0] pat = 8'h3c;
   logic       vld = 1'b0;
   wire drv = !chip_sel_n && !out_en_n && wr_strobe_n
              && !power_fail;
   wire wr_end = chip_sel_n | wr_strobe_n;
   // A change during the wait is missed, so the host must hold its lines.
   always @(addr_in or chip_sel_n or out_en_n) begin
      vld = 1'b0;
      #70 vld = 1'b1;
   end
   always @(posedge clk) pat <= pat + 8'h5b;
   assign dev_d = (drv && vld) ? mem[addr_in] : pat;
   always @(posedge wr_end) begin
      if (!power_fail)
         mem[addr_in] <= host_oe ? host_d : ~host_d;
   end
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
   // One refresh period, far shorter than a second to keep runs short.
   localparam int TICK = 400;
   int          tick_cnt = 0;
   int unsigned tc [7] = '{0, 0, 0, 1, 1, 1, 0};
   logic        upd_pend = 1'b0;
   logic        wh_last = 1'b0;
   function automatic logic [7:0] to_bcd(input int unsigned v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction
   function automatic int unsigned from_bcd(input logic [7:0] b);
      return b[7:4] * 10 + b[3:0];
   endfunction
   // Every fourth year is a leap year, which goes wrong in 2100.
   function automatic int unsigned mdays(input int unsigned m,
                                         input int unsigned y);
      if (m == 2) begin
         return (y % 4 == 0) ? 29 : 28;
      end
      if (m == 4 || m == 6 || m == 9 || m == 11) begin
         return 30;
      end
      return 31;
   endfunction
   // Counters run in binary and are shown as BCD, 24-hour.
   always @(posedge clk) begin
      wh_last  <= mem[11'h7f8][7];
      tick_cnt <= (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
      if (wh_last && !mem[11'h7f8][7]) begin
         // Clearing write-halt loads the counters, a fresh second.
         for (int k = 0; k < 7; k++) begin
            tc[k] = from_bcd(mem[11'h7f9 + k]);
         end
         tick_cnt <= 0;
      end else if (tick_cnt == TICK - 1) begin
         tc[0]++;
         if (tc[0] == 60) begin
            tc[0] = 0;
            tc[1]++;
         end
         if (tc[1] == 60) begin
            tc[1] = 0;
            tc[2]++;
         end
         if (tc[2] == 24) begin
            tc[2] = 0;
            tc[3] = tc[3] % 7 + 1;
            tc[4]++;
         end
         if (tc[4] > mdays(tc[5], tc[6])) begin
            tc[4] = 1;
            tc[5]++;
         end
         if (tc[5] == 13) begin
            tc[5] = 1;
            tc[6] = (tc[6] + 1) % 100;
         end
         upd_pend <= 1'b1;
      end
      // A selected host goes first; either halt bit drops it.
      if (upd_pend && chip_sel_n === 1'b1) begin
         upd_pend <= 1'b0;
         if (mem[11'h7f8][7:6] == 2'b00) begin
            for (int k = 0; k < 7; k++) begin
               mem[11'h7f9 + k] <= to_bcd(tc[k]);
            end
         end
      end
   end
endmodule

// *** verification/test_rtc_sram_async_port.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_rtc_sram_async_port;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        power_fail = 1'b0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [10:0] addr_in;
   wire  [7:0]  data_o;
   wire         data_oe;
   wire  [7:0]  dev_d;
   wire         chip_sel_n;
   wire         out_en_n;
   wire         wr_strobe_n;
   wire  [7:0]  data_i = data_oe ? data_o : dev_d;
   int          bad_count = 0;
   int          check_count = 0;
   always #12.5 clk = ~clk;
   rsap_host dut (.clk, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .power_fail,
      .addr_in, .data_o, .data_oe, .data_i, .chip_sel_n, .out_en_n,
      .wr_strobe_n);
   rsap_dev_model mdl (.clk, .addr_in, .chip_sel_n, .out_en_n,
      .wr_strobe_n, .power_fail, .host_d(data_o), .host_oe(data_oe),
      .dev_d);
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      // The request stands until the edge that sees waitrequest low.
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic dev_op(input logic w, input logic s, input logic [10:0] a,
                         input logic [7:0] d, output logic [31:0] st);
      int n;
      bus(1'b1, 4'h0, 32'h0, st);
      bus(1'b1, 4'h4, {21'h0, a}, st);
      bus(1'b1, 4'h8, {24'h0, d}, st);
      bus(1'b1, 4'h0, {29'h0, s, w, 1'b1}, st);
      n = 0;
      do begin
         bus(1'b0, 4'hc, 32'h0, st);
         n++;
      end while (st[1] !== 1'b1 && n < 40);
   endtask
   task t_reset;
      logic [31:0] q;
      bus(1'b0, 4'hc, 32'h0, q);
      `CHK("status", 32'h0, q)
      bus(1'b0, 4'h2, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
   endtask
   task t_map;
      logic [10:0] a [4] = '{11'h000, 11'h3ff, 11'h7f8, 11'h7ff};
      logic [7:0]  b [4] = '{8'h5a, 8'ha5, 8'h43, 8'h3c};
      logic [31:0] q;
      for (int i = 0; i < 4; i++) begin
         dev_op(1'b1, i[0], a[i], b[i], q);
         `CHK("wr done", 1'b1, q[1])
         `CHK("cell", b[i], mdl.mem[a[i]])
      end
      for (int i = 0; i < 4; i++) begin
         dev_op(1'b0, 1'b0, a[i], 8'h00, q);
         `CHK("rd byte", b[i], q[15:8])
      end
      `CHK("other", 8'h00, mdl.mem[11'h001])
   endtask
   task t_pfail;
      logic [31:0] q;
      power_fail <= 1'b1;
      repeat (4) @(posedge clk);
      dev_op(1'b1, 1'b0, 11'h001, 8'h77, q);
      `CHK("pf flag", 1'b1, q[2])
      `CHK("pf done", 1'b0, q[1])
      `CHK("pf cell", 8'h00, mdl.mem[11'h001])
      power_fail <= 1'b0;
      repeat (4) @(posedge clk);
      dev_op(1'b1, 1'b0, 11'h001, 8'h77, q);
      `CHK("pf after", 8'h77, mdl.mem[11'h001])
   endtask
   task t_clock;
      logic [7:0]  tset [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02,
                                8'h24};
      logic [7:0]  twant [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02,
                                 8'h24};
      logic [31:0] q;
      dev_op(1'b1, 1'b0, 11'h7f8, 8'h80, q);
      for (int i = 0; i < 7; i++) begin
         dev_op(1'b1, i[0], 11'(11'h7f9 + i), tset[i], q);
      end
      dev_op(1'b1, 1'b0, 11'h7f8, 8'h00, q);
      repeat (mdl.TICK) @(posedge clk);
      dev_op(1'b1, 1'b1, 11'h7f8, 8'h40, q);
      for (int i = 0; i < 7; i++) begin
         dev_op(1'b0, 1'b0, 11'(11'h7f9 + i), 8'h00, q);
         `CHK("clock byte", twant[i], q[15:8])
      end
      repeat (mdl.TICK) @(posedge clk);
      dev_op(1'b0, 1'b0, 11'h7f9, 8'h00, q);
      `CHK("halted sec", 8'h00, q[15:8])
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_map();
      t_pfail();
      t_clock();
      end_of_test();
   end
   initial begin
      #200000;
      bad_count++;
      end_of_test();
   end
endmodule
bind rsap_host rsap_host_sva u_sva (.clk, .resetn, .avs_read, .avs_write,
   .avs_waitrequest, .addr_in, .data_o, .data_oe, .chip_sel_n, .out_en_n,
   .wr_strobe_n);
